// ===== hdl/reply_byte_mux.sv
/*
 * Picks the reply byte for a given index from the current run-time settings.
 * Purely combinational; assumes settings_report_defs.svh is on the path.
 */
`include "settings_report_defs.svh"

module reply_byte_mux (
   input  wire logic [5:0] index,
   input  wire logic [7:0] chip_len,
   input  wire logic [7:0] pin_len,
   input  wire logic [7:0] chip_cfg,
   input  wire logic [7:0] clock_out,
   input  wire logic [7:0] dac_cfg,
   output logic      [7:0] reply_byte
);

   // Unlisted bytes and unused bits read as zero.
   always_comb begin
      reply_byte = 8'h00;
      case (index)
         `IDX_ECHO:      reply_byte = `CMD_READ_SETTINGS;
         `IDX_STATUS:    reply_byte = `STATUS_SUCCESS;
         `IDX_CHIP_LEN:  reply_byte = chip_len;
         `IDX_PIN_LEN:   reply_byte = pin_len;
         `IDX_CHIP_CFG: begin
            reply_byte[`SERIAL_ENUM_BIT] = chip_cfg[`SERIAL_ENUM_BIT];
            reply_byte[`SECURITY_MSB:0]  = chip_cfg[`SECURITY_MSB:0];
         end
         `IDX_CLOCK_OUT: begin
            reply_byte[`CLKDIV_DUTY_MSB:`CLKDIV_DUTY_LSB] =
               clock_out[`CLKDIV_DUTY_MSB:`CLKDIV_DUTY_LSB];
            reply_byte[`CLKDIV_RATIO_MSB:0] = clock_out[`CLKDIV_RATIO_MSB:0];
         end
         `IDX_DAC_CFG: begin
            reply_byte[`DAC_LEVEL_MSB:`DAC_LEVEL_LSB] =
               dac_cfg[`DAC_LEVEL_MSB:`DAC_LEVEL_LSB];
            reply_byte[`DAC_SOURCE_BIT]    = dac_cfg[`DAC_SOURCE_BIT];
            reply_byte[`DAC_POWERUP_MSB:0] = dac_cfg[`DAC_POWERUP_MSB:0];
         end
         default:        reply_byte = 8'h00;
      endcase
   end

endmodule : reply_byte_mux

// ===== hdl/runtime_settings_report.sv
/*
 * Builds the 64-byte reply to the read-settings command from the current
 * run-time settings held in Wishbone registers, and streams it out one byte
 * per accepted beat with valid/ready.
 * Assumes one 100 MHz clock, synchronous active-low reset, classic Wishbone.
 * Assumes the command inputs come from logic on the same clock, so they are
 * read without synchronisers; a pulse starts one reply, while a level held high
 * starts it again each time the sequencer returns to idle.
 * Limitation: security code 11 is stored and returned as written, so software
 * that must only ever report the three defined codes has to avoid writing it.
 */
// Decided for this implementation: the Wishbone slave port and the register addresses.
// What this block does
// - Byte 0 echoes command code 0x61; byte 1 reports success 0x00.
// - Byte 2 gives the length of the run-time chip settings area.
// - Byte 3 gives the length of the run-time pin settings area.
// - Byte 4 bit 7 is the serial-number enumeration enable.
// - Byte 4 bits 1-0 hold the security option: locked, password, unsecured.
// - Byte 5 bits 4-0 hold the clock-output divider setting for the 48 MHz clock.
// - Divider bits 4-3 choose duty cycle, bits 2-0 the division ratio.
// - Byte 6 bits 7-6 choose the DAC internal reference level.
// - Byte 6 bit 5 picks internal reference module or supply as DAC reference.
// - Byte 6 bits 4-0 hold the DAC power-up value.
// - A read-settings command returns current run-time settings, not stored defaults.
`include "settings_report_defs.svh"

module runtime_settings_report #(
   // Length of the fixed report; the six-bit index bounds it from above.
   parameter int REPLY_BYTES = int'(`REPLY_LENGTH)
) (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        clock_enable,
   // Wishbone classic slave.
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Command from the report interface.
   input  wire logic        command_valid,
   input  wire logic [7:0]  command_code,
   // Reply stream.
   output logic             reply_valid,
   output logic [7:0]       reply_data,
   output logic             reply_last,
   input  wire logic        reply_ready
);

   ////////////////////////////////////////////////////////////////////////////
   // Timing overview.
   //
   // Bus: a request is taken at the rising edge at which cyc and stb stand
   // high and no ack is pending. Ack and read data follow one cycle later and
   // the ack lasts one cycle, so the master drops its strobe for at least one
   // cycle between accesses. A write lands at the taking edge.
   //
   // Reply: a start in idle loads byte 0 into the output stage at that same
   // edge, so valid rises one cycle after the command. Each byte then holds
   // until ready is seen high. The next byte is read from the live settings
   // as it is loaded, which lets a write made during a reply reach the bytes
   // not yet loaded. After the last byte is taken two cycles pass before a new
   // start counts; starts that arrive while busy are dropped, not queued.
   //
   // A low clock enable freezes the sequencer, the bus answer and the settings.

   ////////////////////////////////////////////////////////////////////////////
   // Elaboration checks.

   // The six-bit index cannot count past 64 bytes, and the report must hold
   // the seven field bytes and at least one trailing byte, so the last flag is
   // never loaded from the start branch. Other lengths are refused here.
   if (REPLY_BYTES < 8 || REPLY_BYTES > 64) begin : g_bad_length
      $error("REPLY_BYTES must lie between 8 and 64");
   end

   // Index of the byte whose acceptance loads the final byte of the report.
   localparam logic [5:0] LAST_LOAD = 6'(REPLY_BYTES - 2);

   ////////////////////////////////////////////////////////////////////////////
   // State.

   // One register holds all sequencer and bus state; settings live apart.
   typedef struct packed {
      settings_report_pkg::reply_state_e fsm;
      logic [5:0]                        index;
      logic                              valid;
      logic [7:0]                        data;
      logic                              last;
      logic                              ack;
      logic [31:0]                       rdata;
      logic [7:0]                        replies;
   } top_s;

   top_s state;
   top_s next_state;

   // Settings bytes, the selected reply byte and the decoded bus strobes.
   logic [7:0] chip_cfg;
   logic [7:0] clock_out;
   logic [7:0] dac_cfg;
   logic [7:0] chip_len;
   logic [7:0] pin_len;
   logic [7:0] mux_byte;
   logic       wb_req;
   logic       wb_write;
   logic       start_sw;
   logic       start_cmd;
   logic [5:0] mux_index;
   logic       chip_cfg_we;
   logic       clock_out_we;
   logic       dac_cfg_we;
   logic       chip_len_we;
   logic       pin_len_we;

   ////////////////////////////////////////////////////////////////////////////
   // Wishbone decode.

   // A request is answered one cycle later; the ack gap keeps each access single.
   assign wb_req   = wb_cyc_i && wb_stb_i && !state.ack;
   assign wb_write = wb_req && wb_we_i && wb_sel_i[0];

   // Software may also trigger a reply, handy when no host command path exists.
   assign start_sw  = wb_write && (wb_adr_i == `REG_CONTROL) && wb_dat_i[`CTRL_START_BIT];
   // Only the read-settings code starts this reply; other codes are not ours.
   assign start_cmd = command_valid && (command_code == `CMD_READ_SETTINGS);

   // Per-register write strobes; the pin length has its own byte lane so that
   // software can update either area length alone.
   assign chip_cfg_we  = wb_write && (wb_adr_i == `REG_CHIP_CFG);
   assign clock_out_we = wb_write && (wb_adr_i == `REG_CLOCK_OUT);
   assign dac_cfg_we   = wb_write && (wb_adr_i == `REG_DAC_CFG);
   assign chip_len_we  = wb_write && (wb_adr_i == `REG_AREA_LEN);
   assign pin_len_we   = wb_req && wb_we_i && wb_sel_i[1] && (wb_adr_i == `REG_AREA_LEN);

   ////////////////////////////////////////////////////////////////////////////
   // Run-time settings held as writable bytes; the reply reads these live.

   // Serial-number enable in bit 7, security option in bits 1-0; the rest stays zero.
   settings_field_reg #(
      .RESET_VALUE (`RST_CHIP_CFG),
      .WRITE_MASK  (8'h83)
   ) chip_cfg_reg (
      .clock   (clock),
      .rst_n   (rst_n),
      .enable  (clock_enable),
      .write   (chip_cfg_we),
      .data_in (wb_dat_i[7:0]),
      .value   (chip_cfg)
   );

   // Duty cycle in bits 4-3 and division ratio in bits 2-0; bits 7-5 stay zero.
   settings_field_reg #(
      .RESET_VALUE (`RST_CLOCK_OUT),
      .WRITE_MASK  (8'h1f)
   ) clock_out_reg (
      .clock   (clock),
      .rst_n   (rst_n),
      .enable  (clock_enable),
      .write   (clock_out_we),
      .data_in (wb_dat_i[7:0]),
      .value   (clock_out)
   );

   // Reference level, reference source and power-up value fill the whole byte.
   settings_field_reg #(
      .RESET_VALUE (`RST_DAC_CFG),
      .WRITE_MASK  (8'hff)
   ) dac_cfg_reg (
      .clock   (clock),
      .rst_n   (rst_n),
      .enable  (clock_enable),
      .write   (dac_cfg_we),
      .data_in (wb_dat_i[7:0]),
      .value   (dac_cfg)
   );

   // Area lengths live in one register, chip length low byte, pin length next.
   settings_field_reg #(
      .RESET_VALUE (`RST_CHIP_LEN),
      .WRITE_MASK  (8'hff)
   ) chip_len_reg (
      .clock   (clock),
      .rst_n   (rst_n),
      .enable  (clock_enable),
      .write   (chip_len_we),
      .data_in (wb_dat_i[7:0]),
      .value   (chip_len)
   );

   // Pin length rides in the second byte lane of the same register.
   settings_field_reg #(
      .RESET_VALUE (`RST_PIN_LEN),
      .WRITE_MASK  (8'hff)
   ) pin_len_reg (
      .clock   (clock),
      .rst_n   (rst_n),
      .enable  (clock_enable),
      .write   (pin_len_we),
      .data_in (wb_dat_i[15:8]),
      .value   (pin_len)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Reply byte selection.

   reply_byte_mux byte_mux (
      .index      (mux_index),
      .chip_len   (chip_len),
      .pin_len    (pin_len),
      .chip_cfg   (chip_cfg),
      .clock_out  (clock_out),
      .dac_cfg    (dac_cfg),
      .reply_byte (mux_byte)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer and bus answer.

   // The mux looks at the byte about to be loaded into the output stage.
   always_comb begin
      mux_index = 6'h00;
      if (state.fsm == settings_report_pkg::send_state) begin
         mux_index = state.index + 6'h01;
      end
   end

   // Bytes are sampled live at load time, so the report shows current settings.
   always_comb begin
      next_state     = state;
      next_state.ack = wb_req;
      // Read data is captured with the ack and stands until the next read.
      if (wb_req && !wb_we_i) begin
         unique case (wb_adr_i)
            `REG_STATUS:    next_state.rdata = {16'h0000, state.replies, 6'h00,
                                                state.fsm};
            `REG_CHIP_CFG:  next_state.rdata = {24'h000000, chip_cfg};
            `REG_CLOCK_OUT: next_state.rdata = {24'h000000, clock_out};
            `REG_DAC_CFG:   next_state.rdata = {24'h000000, dac_cfg};
            `REG_AREA_LEN:  next_state.rdata = {16'h0000, pin_len, chip_len};
            default:        next_state.rdata = 32'h00000000;
         endcase
      end
      unique case (state.fsm)
         settings_report_pkg::idle_state: begin
            // Wait for a host command or a software start.
            if (start_cmd || start_sw) begin
               next_state.fsm   = settings_report_pkg::send_state;
               next_state.index = 6'h00;
               next_state.valid = 1'b1;
               next_state.data  = mux_byte;
               next_state.last  = 1'b0;
            end
         end
         settings_report_pkg::send_state: begin
            // Advance one byte per accepted beat; hold the byte while ready is low.
            if (reply_ready) begin
               if (state.last) begin
                  next_state.fsm   = settings_report_pkg::done_state;
                  next_state.valid = 1'b0;
                  next_state.last  = 1'b0;
                  next_state.data  = 8'h00;
               end else begin
                  next_state.index = state.index + 6'h01;
                  next_state.data  = mux_byte;
                  // The flag rides with the final byte of the fixed-length report.
                  next_state.last  = (state.index == LAST_LOAD);
               end
            end
         end
         settings_report_pkg::done_state: begin
            // One settle cycle that also counts the finished report.
            next_state.fsm     = settings_report_pkg::idle_state;
            next_state.replies = state.replies + 8'h01;
         end
         default: begin
            // Code 11 is never entered; recover to idle should it appear.
            next_state.fsm = settings_report_pkg::idle_state;
         end
      endcase
   end

   // All state moves only while the clock enable is high.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state.fsm     <= settings_report_pkg::idle_state;
         state.index   <= 6'h00;
         state.valid   <= 1'b0;
         state.data    <= 8'h00;
         state.last    <= 1'b0;
         state.ack     <= 1'b0;
         state.rdata   <= 32'h00000000;
         state.replies <= 8'h00;
      end else if (clock_enable) begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, each taken straight from the state register.

   assign wb_dat_o    = state.rdata;
   assign wb_ack_o    = state.ack;
   assign reply_valid = state.valid;
   assign reply_data  = state.data;
   assign reply_last  = state.last;

endmodule : runtime_settings_report

// ===== hdl/settings_field_reg.sv
/*
 * One software-written settings byte with write-enable and mask; the parent picks the byte lane.
 * Assumes a single clock, synchronous active-low reset and a clock enable.
 */
module settings_field_reg #(
   parameter logic [7:0] RESET_VALUE = 8'h00,
   parameter logic [7:0] WRITE_MASK  = 8'hff
) (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       enable,
   input  wire logic       write,
   input  wire logic [7:0] data_in,
   output logic      [7:0] value
);

   typedef struct packed {
      logic [7:0] value;
   } field_s;

   field_s state;
   field_s next_state;

   // Masked-off bits stay zero so don't-care bits never leak into the reply.
   always_comb begin
      next_state = state;
      if (write) begin
         next_state.value = data_in & WRITE_MASK;
      end
   end

   // Register the field; clock enable freezes it.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state.value <= RESET_VALUE & WRITE_MASK;
      end else if (enable) begin
         state <= next_state;
      end
   end

   assign value = state.value;

endmodule : settings_field_reg

// ===== include/settings_report_defs.svh
/*
 * Constants of the run-time settings report block: register byte addresses,
 * reply byte indices, field positions, reset values and fixed codes.
 * Assumes it is included by bare name from the design files.
 */
`ifndef SETTINGS_REPORT_DEFS_SVH
`define SETTINGS_REPORT_DEFS_SVH

// Wishbone register byte addresses.
`define REG_CONTROL        8'h00
`define REG_STATUS         8'h04
`define REG_CHIP_CFG       8'h08
`define REG_CLOCK_OUT      8'h0c
`define REG_DAC_CFG        8'h10
`define REG_AREA_LEN       8'h14

// Control register bits (write one to act).
`define CTRL_START_BIT     0

// Fixed reply codes.
`define CMD_READ_SETTINGS  8'h61
`define STATUS_SUCCESS     8'h00
`define REPLY_LENGTH       7'h40

// Reply byte indices.
`define IDX_ECHO           6'h00
`define IDX_STATUS         6'h01
`define IDX_CHIP_LEN       6'h02
`define IDX_PIN_LEN        6'h03
`define IDX_CHIP_CFG       6'h04
`define IDX_CLOCK_OUT      6'h05
`define IDX_DAC_CFG        6'h06

// Field positions inside the reply bytes.
`define SERIAL_ENUM_BIT    7
`define SECURITY_MSB       1
`define CLKDIV_DUTY_MSB    4
`define CLKDIV_DUTY_LSB    3
`define CLKDIV_RATIO_MSB   2
`define DAC_LEVEL_MSB      7
`define DAC_LEVEL_LSB      6
`define DAC_SOURCE_BIT     5
`define DAC_POWERUP_MSB    4

// Reset values of the run-time settings.
`define RST_CHIP_CFG       8'h00
`define RST_CLOCK_OUT      8'h00
`define RST_DAC_CFG        8'h00
`define RST_CHIP_LEN       8'h00
`define RST_PIN_LEN        8'h00

`endif

// ===== include/settings_report_pkg.sv
/*
 * Types shared by the settings report block.
 * Assumes settings_report_defs.svh is on the include path.
 */
package settings_report_pkg;

   // Reply sequencer states.
   typedef enum logic [1:0] {
      idle_state = 2'b00,
      send_state = 2'b01,
      done_state = 2'b10
   } reply_state_e;

   // Security option codes.
   typedef enum logic [1:0] {
      unsecured   = 2'b00,
      password    = 2'b01,
      locked      = 2'b10
   } security_e;

endpackage : settings_report_pkg

// ===== verification/host_model.sv
/* Behavioural host: issues commands and collects reply bytes.
   Assumes the bench seeds $urandom and calls its tasks one at a time. */
module host_model (
   input  wire logic       clock,
   input  wire logic       clock_enable,
   input  wire logic       slow,
   input  wire logic       reply_valid,
   input  wire logic [7:0] reply_data,
   input  wire logic       reply_last,
   output logic            command_valid,
   output logic [7:0]      command_code,
   output logic            reply_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] rx [64];
   int         rx_n = 0;
   int         last_at = -1;
   initial begin
      command_valid = 1'b0;
      command_code = 8'h00;
      reply_ready = 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // A slow host stalls at random, changing ready just after each rising edge.
   always @(posedge clock) begin
      reply_ready <= slow ? 1'($urandom_range(1, 0)) : 1'b1;
   end
   // A byte is taken at the rising edge at which valid and ready stand together
   // and the block is not frozen; the values seen are those before the edge.
   always @(posedge clock) begin
      if (clock_enable && reply_valid && reply_ready) begin
         if (rx_n < 64)
            rx[rx_n] <= reply_data;
         if (reply_last)
            last_at <= rx_n;
         rx_n <= rx_n + 1;
      end
   end
   task clear;
      @(posedge clock);
      rx_n <= 0;
      last_at <= -1;
   endtask : clear
   // Released code lines show the inverse, so a stale code is never mistaken.
   task send_command(input logic [7:0] code);
      @(posedge clock);
      command_valid <= 1'b1;
      command_code <= code;
      @(posedge clock);
      command_valid <= 1'b0;
      command_code <= ~code;
   endtask : send_command
endmodule : host_model

// ===== verification/report_checker.sv
/* Assertions on the reply stream and bus handshake of the settings report.
   Assumes it is bound to runtime_settings_report and sees only its ports. */
module report_checker (
   input wire logic       clock,
   input wire logic       rst_n,
   input wire logic       clock_enable,
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic       wb_ack_o,
   input wire logic       reply_valid,
   input wire logic [7:0] reply_data,
   input wire logic       reply_last,
   input wire logic       reply_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [5:0] beat;
   ////////////////////////////////////////////////////////////////////////////////
   // Counts accepted bytes, so every byte can be tied to its index in the reply.
   always_ff @(posedge clock) begin
      if (!rst_n)
         beat <= 6'h00;
      else if (clock_enable && reply_valid && reply_ready)
         beat <= reply_last ? 6'h00 : beat + 6'h01;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence s_wb_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o && clock_enable;
   endsequence
   sequence s_take_last;
      reply_valid && reply_ready && reply_last && clock_enable;
   endsequence
   wb_ack_timing_a: assert property (s_wb_take |=> wb_ack_o)
      else $error("bus ack late");
   wb_ack_pulse_a: assert property (wb_ack_o && clock_enable |=> !wb_ack_o)
      else $error("bus ack too long");
   echo_first_a: assert property (
      $rose(reply_valid) |-> reply_data == 8'h61 && beat == 6'h00)
      else $error("reply does not open with echo");
   status_byte_a: assert property (
      reply_valid && beat == 6'h01 |-> reply_data == 8'h00)
      else $error("status byte wrong");
   chip_byte_a: assert property (
      reply_valid && beat == 6'h04 |-> reply_data[6:2] == 5'h00)
      else $error("chip byte unused bits set");
   clock_byte_a: assert property (
      reply_valid && beat == 6'h05 |-> reply_data[7:5] == 3'h0)
      else $error("clock byte upper bits set");
   tail_zero_a: assert property (
      reply_valid && beat >= 6'h07 |-> reply_data == 8'h00)
      else $error("tail byte not zero");
   last_index_a: assert property (
      reply_valid |-> reply_last == (beat == 6'h3f))
      else $error("last flag on wrong byte");
   last_end_a: assert property (s_take_last |=> !reply_valid)
      else $error("stream runs past last byte");
   hold_byte_a: assert property (
      reply_valid && !reply_ready |=> reply_valid && $stable(reply_data))
      else $error("byte changed while stalled");
endmodule : report_checker

bind runtime_settings_report report_checker i_chk (.clock(clock), .rst_n(rst_n),
   .clock_enable(clock_enable), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .reply_valid(reply_valid), .reply_data(reply_data), .reply_last(reply_last),
   .reply_ready(reply_ready));

// ===== verification/tb.sv
/* Self-checking bench for the settings report: registers over Wishbone,
   replies through the host model. Assumes a 100 MHz clock. */
module tb;
   timeunit 1ns;
   timeprecision 1ns;
`define CHECK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin fail_count++; \
   $display("unexpected %s expected %h seen %h", what, exp, got); end end
   logic        clock, rst_n, ce, cyc, stb, we, wb_ack_o, command_valid;
   logic        reply_valid, reply_last, reply_ready, slow;
   logic [7:0]  adr, command_code, reply_data, chip, clk_cfg, dac, clen, plen;
   logic [31:0] wdat, rdat, wb_dat_o;
   int          fail_count, num_checks, n;
   runtime_settings_report i_runtime_settings_report (.clock(clock), .rst_n(rst_n),
      .clock_enable(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .command_valid(command_valid), .command_code(command_code), .reply_valid(reply_valid),
      .reply_data(reply_data), .reply_last(reply_last), .reply_ready(reply_ready));
   host_model host (.clock(clock), .clock_enable(ce), .slow(slow), .reply_valid(reply_valid),
      .reply_data(reply_data), .reply_last(reply_last), .command_valid(command_valid),
      .command_code(command_code), .reply_ready(reply_ready));
   ////////////////////////////////////////////////////////////////////////////////
   // Expected reply byte from the settings last written.
   function automatic logic [7:0] exp_byte(input int b);
      case (b)
         0: return 8'h61;
         2: return clen;
         3: return plen;
         4: return {chip[7], 5'h00, chip[1:0]};
         5: return {3'h0, clk_cfg[4:0]};
         6: return dac;
         default: return 8'h00;
      endcase
   endfunction : exp_byte
   // One classic cycle: ack is sampled at the rising edge, read data is taken
   // there, and the request is released at that same edge.
   task wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clock);
      end while (wb_ack_o !== 1'b1);
      rdat = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb_cycle
   task finish_test;
      if (fail_count == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : finish_test
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // A stuck handshake ends the run here instead of hanging it.
   initial begin
      repeat (20000) @(posedge clock);
      fail_count++;
      finish_test();
   end
   initial begin
      void'($urandom(11));
      {rst_n, ce, cyc, stb, we, adr, wdat, slow, fail_count, num_checks} = '0;
      ce = 1'b1;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      for (int a = 8; a <= 20; a += 4) begin
         wb_cycle(1'b0, 8'(a), 32'h0);
         `CHECK("reset value", 32'h0, rdat)
      end
      host.send_command(8'h60);
      repeat (10) @(posedge clock);
      `CHECK("stray reply", 0, host.rx_n)
      for (int i = 0; i < 8; i++) begin
         {chip, clk_cfg, dac, clen, plen} = {$urandom, 8'($urandom)};
         if (i == 0)
            {clk_cfg, dac, clen, plen} = '0;
         if (i == 7)
            {clk_cfg, dac, clen, plen} = '1;
         chip[7] = i[2];
         chip[1:0] = i[1:0];
         dac[7:5] = 3'(i);
         slow <= i[0];
         wb_cycle(1'b1, 8'h08, {24'h0, chip});
         wb_cycle(1'b1, 8'h0c, {24'h0, clk_cfg});
         wb_cycle(1'b1, 8'h10, {24'h0, dac});
         wb_cycle(1'b1, 8'h14, {16'h0, plen, clen});
         wb_cycle(1'b0, 8'h08, 32'h0);
         `CHECK("chip setting", chip & 8'h83, rdat[7:0])
         host.clear();
         if (i[1])
            wb_cycle(1'b1, 8'h00, 32'h1);
         else
            host.send_command(8'h61);
         repeat (6) @(posedge clock);
         host.send_command(8'h61);
         // A frozen block must neither drop nor repeat a byte.
         if (i == 5) begin
            ce <= 1'b0;
            repeat (4) @(posedge clock);
            ce <= 1'b1;
         end
         n = 0;
         while (host.rx_n < 64 && n < 400) begin
            @(posedge clock);
            n++;
         end
         repeat (6) @(posedge clock);
         `CHECK("reply length", 64, host.rx_n)
         `CHECK("last index", 63, host.last_at)
         for (int b = 0; b < 64; b++)
            `CHECK("reply byte", exp_byte(b), host.rx[b])
         wb_cycle(1'b0, 8'h04, 32'h0);
         `CHECK("reply total", {8'(i + 1), 6'h00, 2'h0}, rdat[15:0])
      end
      wb_cycle(1'b1, 8'h3c, 32'hffffffff);
      wb_cycle(1'b0, 8'h3c, 32'h0);
      `CHECK("unmapped", 32'h0, rdat)
      finish_test();
   end
endmodule : tb
